// ---- include/clk_rst_pkg.sv ----
// Constants for the clock, reset and power gating block
// Assumes a single system clock of 20 MHz and an active low async power-on reset
package clk_rst_pkg;

   // ****************************************
   // Timing
   // ****************************************
   localparam int CLK_PERIOD_NS = 50;
   localparam int RST_HOLD_NS   = 1000;
   localparam int RST_HOLD_CYC  = (RST_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // ****************************************
   // Widths
   // ****************************************
   localparam int ADDR_W     = 4;
   localparam int DATA_W     = 32;
   localparam int STRAP_W    = 8;
   localparam int NUM_MOD    = 15;
   localparam int NUM_SINGLE = 6;

   // ****************************************
   // Module reset outputs
   // ****************************************
   localparam int M_SW_FABRIC = 0;
   localparam int M_SW_LOGIC  = 1;
   localparam int M_SW_REGS   = 2;
   localparam int M_MAC0      = 3;
   localparam int M_MAC1      = 4;
   localparam int M_MAC2      = 5;
   localparam int M_PHY_A     = 6;
   localparam int M_PHY_B     = 7;
   localparam int M_VPHY0     = 8;
   localparam int M_VPHY1     = 9;
   localparam int M_TS_CLK    = 10;
   localparam int M_TS0       = 11;
   localparam int M_TS1       = 12;
   localparam int M_TS2       = 13;
   localparam int M_MGMT      = 14;

   localparam logic [NUM_MOD-1:0] CHIP_MASK    = 15'h7fff;
   localparam logic [NUM_MOD-1:0] DIGITAL_MASK = 15'h7c3f;
   localparam logic [NUM_MOD-1:0] PHY_A_MASK   = 15'h0040;
   localparam logic [NUM_MOD-1:0] PHY_B_MASK   = 15'h0080;
   localparam logic [NUM_MOD-1:0] VPHY0_MASK   = 15'h0100;
   localparam logic [NUM_MOD-1:0] VPHY1_MASK   = 15'h0200;
   localparam logic [NUM_MOD-1:0] SWITCH_MASK  = 15'h003f;
   localparam logic [NUM_MOD-1:0] TS_MASK      = 15'h3c00;
   localparam logic [NUM_SINGLE-1:0][NUM_MOD-1:0] SINGLE_MASK =
      {TS_MASK, SWITCH_MASK, VPHY1_MASK, VPHY0_MASK, PHY_B_MASK, PHY_A_MASK};

   // ****************************************
   // Register map
   // ****************************************
   localparam logic [ADDR_W-1:0] CTRL_OFS   = 4'h0;
   localparam logic [ADDR_W-1:0] RESET_OFS  = 4'h4;
   localparam logic [ADDR_W-1:0] STATUS_OFS = 4'h8;
   localparam logic [ADDR_W-1:0] STRAP_OFS  = 4'hc;

   localparam int CTRL_OSC_DIS     = 0;
   localparam int CTRL_PLL_DIS     = 1;
   localparam int CTRL_TEST        = 2;
   localparam int RESET_DIG        = 0;
   localparam int RESET_SINGLE_LSB = 1;
   localparam int ST_PWR_LSB       = 0;
   localparam int ST_PLL_ON        = 3;
   localparam int ST_OSC_ON        = 4;
   localparam int ST_STRAP_VALID   = 5;

   // ****************************************
   // Power state
   // ****************************************
   typedef enum logic [2:0] {
      PWR_RUN     = 3'h1,
      PWR_PLL_OFF = 3'h2,
      PWR_OSC_OFF = 3'h4
   } pwr_e;

endpackage : clk_rst_pkg

// ---- include/reset_req_if.sv ----
// Request and synchronised reset for one module reset line
// Assumes both ends run on the same system clock
`timescale 1ns/1ps
interface reset_req_if;
   logic req;
   logic rst_out_b;
   modport src (output req, input rst_out_b);
   modport dst (input req, output rst_out_b);
endinterface : reset_req_if

// ---- design/rst_release_sync.sv ----
// One module reset line: holds reset for a minimum time, releases on a clean edge
// Assumes req is a one-cycle or level request from logic on clk
`timescale 1ns/1ps
module rst_release_sync
   import clk_rst_pkg::*;
#(
   parameter int HOLD = RST_HOLD_CYC
) (
   input wire logic   clk,
   input wire logic   rst_b,
   reset_req_if.dst   port
);

   localparam int CW = $clog2(HOLD + 1);
   localparam logic [CW-1:0] HOLD_V = CW'(HOLD);

   typedef struct packed {
      logic [CW-1:0] cnt;
      logic [1:0]    stage;
   } state_s;

   state_s st;
   state_s next_st;

   // ****************************************
   // Hold and release
   // ****************************************
   always_comb begin
      next_st = st;
      if (port.req) begin
         next_st.cnt   = HOLD_V;                                 // R11
         next_st.stage = 2'h0;
      end else if (st.cnt != '0) begin
         next_st.cnt   = st.cnt - CW'(1);
         next_st.stage = 2'h0;
      end else begin
         next_st.stage = {st.stage[0], 1'b1};                    // R12
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         st <= '{cnt: HOLD_V, stage: 2'h0};
      end else begin
         st <= next_st;
      end
   end

   assign port.rst_out_b = st.stage[1];

   // ****************************************
   // Checks
   // ****************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   req_assert_a: assert property (port.req |=> !port.rst_out_b)   // R11
      else $error("Reset not asserted after request");
   clean_release_a: assert property ($rose(port.rst_out_b) |-> $past(st.cnt, 2) == '0) // R12
      else $error("Reset released before hold time elapsed");

endmodule : rst_release_sync

// ---- design/clock_reset_distribution.sv ----
// Clock gating, reset grouping, strap capture and clock test routing
// Assumes clk is the derived system clock; PHY power-down flags and irq_req come from clk logic
`timescale 1ns/1ps

// Contract
// R01: Board supplies a fixed 25 MHz reference by crystal or single-ended clock.
// R02: A single-ended reference keeps running throughout normal operation.
// R03: Tolerate a halted reference in power saving and resume when it returns.
// R04: Chip power management can switch the crystal oscillator off.
// R05: Clock-output test mode routes oscillator output onto the interrupt pin.
// R06: The PLL makes the main system clock from which all clocks derive.
// R07: PLL stops only when requested and both PHY ports are powered down.
// R08: Resets grouped as chip-level, digital multi-module and single-module.
// R09: Straps latched when the last chip-level reset releases, used as defaults.
// R10: Chip resets hit every module; digital reset spares PHYs and virtual PHYs.
// R11: A single-module reset touches only its module, not straps or clock. The switch and timestamp single resets hit 6 and 4 modules.
// R12: Each module leaves reset synchronised to the system clock.
module clock_reset_distribution
   import clk_rst_pkg::*;
(
   input  wire logic                clk,
   input  wire logic                rst_b,
   input  wire logic                reset_pin_b,
   input  wire logic                oscillator_input_pin,
   output logic                     oscillator_output_pin,
   input  wire logic                phy_a_power_down,
   input  wire logic                phy_b_power_down,
   input  wire logic                wake_req,
   input  wire logic                irq_req,
   output logic                     irq_pin,
   input  wire logic [STRAP_W-1:0]  strap_pins,
   input  wire logic [ADDR_W-1:0]   addr,
   input  wire logic [DATA_W-1:0]   wdata,
   input  wire logic                wr,
   input  wire logic                rd,
   output logic [DATA_W-1:0]        rdata,
   output logic                     osc_enable,
   output logic                     pll_enable,
   output logic [NUM_MOD-1:0]       module_rst_b,
   output logic [STRAP_W-1:0]       strap_value,
   output logic                     strap_valid
);

   typedef struct packed {
      logic [1:0]            pin_sync;
      logic [1:0]            osc_sync;
      logic                  osc_prev;
      logic [STRAP_W-1:0]    strap_meta;
      logic [STRAP_W-1:0]    strap_sync;
      logic                  chip_prev;
      logic                  strap_ok;
      logic [STRAP_W-1:0]    strap;
      pwr_e                  pwr;
      logic                  osc_dis;
      logic                  pll_dis;
      logic                  test;
      logic                  dig;
      logic [NUM_SINGLE-1:0] single;
      logic [DATA_W-1:0]     rdata;
      logic                  irq;
      logic                  osc_out;
   } state_s;

   localparam state_s RESET_ST = '{
      pin_sync: 2'h0, osc_sync: 2'h0, osc_prev: 1'b0, strap_meta: '0, strap_sync: '0,
      chip_prev: 1'b1, strap_ok: 1'b0, strap: '0, pwr: PWR_RUN, osc_dis: 1'b0,
      pll_dis: 1'b0, test: 1'b0, dig: 1'b0, single: '0, rdata: '0, irq: 1'b0,
      osc_out: 1'b0};

   state_s             st;
   state_s             next_st;
   logic               chip_rst;
   logic               both_pd;
   logic               osc_edge;
   logic [NUM_MOD-1:0] mod_req;

   assign chip_rst = !st.pin_sync[1];
   assign both_pd  = phy_a_power_down && phy_b_power_down;
   assign osc_edge = st.osc_sync[1] != st.osc_prev;

   // ****************************************
   // Reset request grouping
   // ****************************************
   always_comb begin
      mod_req = '0;
      if (chip_rst) begin
         mod_req = CHIP_MASK;                                    // R08 R10
      end
      if (st.dig) begin
         mod_req = mod_req | DIGITAL_MASK;                       // R10
      end
      for (int i = 0; i < NUM_SINGLE; i++) begin
         if (st.single[i]) begin
            mod_req = mod_req | SINGLE_MASK[i];                  // R11
         end
      end
   end

   // ****************************************
   // Next state
   // ****************************************
   always_comb begin
      next_st            = st;
      next_st.pin_sync   = {st.pin_sync[0], reset_pin_b};
      next_st.osc_sync   = {st.osc_sync[0], oscillator_input_pin}; // R01
      next_st.osc_prev   = st.osc_sync[1];
      next_st.strap_meta = strap_pins;
      next_st.strap_sync = st.strap_meta;
      next_st.chip_prev  = chip_rst;
      next_st.dig        = 1'b0;
      next_st.single     = '0;
      next_st.rdata      = '0;

      if (chip_rst) begin
         next_st.strap_ok = 1'b0;
      end else if (st.chip_prev) begin
         next_st.strap     = st.strap_sync;                      // R09
         next_st.strap_ok  = 1'b1;
      end

      if (wr) begin
         unique case (addr)
            CTRL_OFS: begin
               next_st.osc_dis = wdata[CTRL_OSC_DIS];
               next_st.pll_dis = wdata[CTRL_PLL_DIS];
               next_st.test    = wdata[CTRL_TEST];
            end
            RESET_OFS: begin
               next_st.dig    = wdata[RESET_DIG];
               next_st.single = wdata[RESET_SINGLE_LSB +: NUM_SINGLE];
            end
            default: begin
            end
         endcase
      end
      if (wake_req) begin
         next_st.osc_dis = 1'b0;                                 // R03
      end

      if (rd) begin
         unique case (addr)
            CTRL_OFS: begin
               next_st.rdata[CTRL_OSC_DIS] = st.osc_dis;
               next_st.rdata[CTRL_PLL_DIS] = st.pll_dis;
               next_st.rdata[CTRL_TEST]    = st.test;
            end
            STATUS_OFS: begin
               next_st.rdata[ST_PWR_LSB +: $bits(pwr_e)] = st.pwr;
               next_st.rdata[ST_PLL_ON]        = pll_enable;
               next_st.rdata[ST_OSC_ON]        = osc_enable;
               next_st.rdata[ST_STRAP_VALID]   = st.strap_ok;
            end
            STRAP_OFS: begin
               next_st.rdata[STRAP_W-1:0] = st.strap;
            end
            default: begin
            end
         endcase
      end

      unique case (st.pwr)
         PWR_RUN: begin
            if (both_pd && st.osc_dis) begin
               next_st.pwr = PWR_OSC_OFF;                        // R04
            end else if (both_pd && st.pll_dis) begin
               next_st.pwr = PWR_PLL_OFF;                        // R07
            end
         end
         PWR_PLL_OFF: begin
            if (both_pd && st.osc_dis) begin
               next_st.pwr = PWR_OSC_OFF;                        // R04
            end else if (!(both_pd && st.pll_dis)) begin
               next_st.pwr = PWR_RUN;                            // R07
            end
         end
         PWR_OSC_OFF: begin
            if (!both_pd || (!st.osc_dis && osc_edge)) begin
               next_st.pwr = PWR_RUN;                            // R03
            end
         end
         default: begin
            next_st.pwr = PWR_RUN;
         end
      endcase

      next_st.irq     = st.test ? st.osc_sync[1] : irq_req;      // R05
      next_st.osc_out = (st.pwr != PWR_OSC_OFF) && !st.osc_sync[1];
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         st <= RESET_ST;
      end else begin
         st <= next_st;
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   assign pll_enable            = st.pwr == PWR_RUN;             // R06 R07
   assign osc_enable            = st.pwr != PWR_OSC_OFF;         // R04
   assign oscillator_output_pin = st.osc_out;
   assign irq_pin               = st.irq;
   assign rdata                 = st.rdata;
   assign strap_value           = st.strap;
   assign strap_valid           = st.strap_ok;

   // ****************************************
   // Per-module release synchronisers
   // ****************************************
   for (genvar m = 0; m < NUM_MOD; m++) begin : g_mod
      reset_req_if rif ();
      assign rif.req      = mod_req[m];
      assign module_rst_b[m] = rif.rst_out_b;
      rst_release_sync #(
         .HOLD (RST_HOLD_CYC)
      ) u_sync (
         .clk   (clk),
         .rst_b (rst_b),
         .port  (rif.dst)                                        // R12
      );
   end

   // ****************************************
   // Checks
   // ****************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   sequence chip_release_s;
      st.chip_prev && !chip_rst;
   endsequence

   sequence dig_only_s;
      st.dig && !chip_rst && st.single == '0;
   endsequence

   strap_latch_a: assert property (chip_release_s |=> // R09
      strap_valid && strap_value == $past(st.strap_sync))
      else $error("Straps not latched at chip reset release");
   strap_keep_a: assert property (st.single != '0 && !chip_rst |=> $stable(strap_value)) // R11
      else $error("Single-module reset disturbed straps");
   chip_reset_a: assert property (chip_rst |=> module_rst_b == '0) // R10
      else $error("Chip reset did not reach every module");
   dig_reset_a: assert property (dig_only_s |=> (module_rst_b & DIGITAL_MASK) == '0) // R10
      else $error("Digital reset missed a module");
   pll_gate_a: assert property (!both_pd |=> pll_enable)          // R07
      else $error("PLL stopped while a PHY was powered");
   osc_off_a: assert property (st.pwr != PWR_OSC_OFF && both_pd && st.osc_dis // R04
      |=> !osc_enable)
      else $error("Oscillator not switched off on request");
   test_route_a: assert property (st.test |=> irq_pin == $past(st.osc_sync[1])) // R05
      else $error("Oscillator not routed to interrupt pin");
   resume_a: assert property (st.pwr == PWR_OSC_OFF && !st.osc_dis && osc_edge // R03
      |=> pll_enable)
      else $error("Did not resume after clock returned");

endmodule : clock_reset_distribution

// ---- test/board_clock_source.sv ----
// Board side model: 25 MHz reference source and external reset pin
// Assumes the bench commands halts and pin presses between its own clock edges
`timescale 1ns/1ps
module board_clock_source #(
   parameter int HALF_NS = 20
) (
   input  wire logic halt,
   input  wire logic pin_req,
   output logic      osc,
   output logic      pin_b
);
   // ****************************************
   // Reference and reset pin
   // ****************************************
   initial begin
      osc = 1'b0;
      forever begin
         #(HALF_NS);
         if (!halt) begin
            osc = ~osc;
         end
      end
   end

   assign pin_b = ~pin_req;
endmodule : board_clock_source

// ---- test/clock_reset_distribution_tb.sv ----
// Self-checking bench for the clock, reset and power gating block
// Assumes the board model supplies the reference and the reset pin
`timescale 1ns/1ps
module clock_reset_distribution_tb
   import clk_rst_pkg::*;
;
   logic               clk;
   logic               rst_b;
   logic               halt;
   logic               pin_req;
   logic               pin_b;
   logic               osc;
   logic               osc_out;
   logic               pd_a;
   logic               pd_b;
   logic               wake;
   logic               irq_req;
   logic               irq_pin;
   logic [STRAP_W-1:0] straps;
   logic [ADDR_W-1:0]  addr;
   logic [DATA_W-1:0]  wdata;
   logic               wr;
   logic               rd;
   logic [DATA_W-1:0]  rdata;
   logic               osc_en;
   logic               pll_en;
   logic [NUM_MOD-1:0] mods;
   logic [STRAP_W-1:0] strap_val;
   logic               strap_ok;
   logic [DATA_W-1:0]  d;
   logic               prev;
   int                 flips;
   int                 n;
   int                 mismatches;
   int                 samples_checked;

   // ****************************************
   // Clock, board model and design
   // ****************************************
   initial begin
      clk = 1'b0;
      forever #(CLK_PERIOD_NS / 2) clk = ~clk;
   end

   board_clock_source board (.halt(halt), .pin_req(pin_req), .osc(osc), .pin_b(pin_b));

   clock_reset_distribution DUT (
      .clk                  (clk),
      .rst_b                (rst_b),
      .reset_pin_b          (pin_b),
      .oscillator_input_pin (osc),
      .oscillator_output_pin(osc_out),
      .phy_a_power_down     (pd_a),
      .phy_b_power_down     (pd_b),
      .wake_req             (wake),
      .irq_req              (irq_req),
      .irq_pin              (irq_pin),
      .strap_pins           (straps),
      .addr                 (addr),
      .wdata                (wdata),
      .wr                   (wr),
      .rd                   (rd),
      .rdata                (rdata),
      .osc_enable           (osc_en),
      .pll_enable           (pll_en),
      .module_rst_b         (mods),
      .strap_value          (strap_val),
      .strap_valid          (strap_ok)
   );

   // ****************************************
   // Tasks
   // ****************************************
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         mismatches++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   function automatic logic [DATA_W-1:0] status_word(input pwr_e p, input logic valid);
      logic [DATA_W-1:0] w;
      w                             = '0;
      w[ST_PWR_LSB +: $bits(pwr_e)] = p;
      w[ST_PLL_ON]                  = p == PWR_RUN;
      w[ST_OSC_ON]                  = p != PWR_OSC_OFF;
      w[ST_STRAP_VALID]             = valid;
      return w;
   endfunction : status_word

   function automatic logic [DATA_W-1:0] released_except(input logic [NUM_MOD-1:0] m);
      return DATA_W'(CHIP_MASK & ~m);
   endfunction : released_except

   task automatic cyc(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask : cyc

   task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
      @(posedge clk);
      wr    <= 1'b1;
      addr  <= a;
      wdata <= v;
      @(posedge clk);
      wr <= 1'b0;
   endtask : wr_reg

   task automatic rd_reg(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] v);
      @(posedge clk);
      rd   <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1 v = rdata;
   endtask : rd_reg

   task automatic wait_mods();
      n = 0;
      while (mods !== CHIP_MASK && n < 100) begin
         cyc(1);
         n++;
      end
      chk("module resets released", 32'(CHIP_MASK), 32'(mods));
   endtask : wait_mods

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : wrap_up

   initial begin
      #(CLK_PERIOD_NS * 5000);
      mismatches++;
      wrap_up();
   end

   // ****************************************
   // Scenarios
   // ****************************************
   initial begin
      void'($urandom(48));
      mismatches = 0;
      samples_checked = 0;
      {rst_b, halt, pin_req, pd_a, pd_b, wake, irq_req, wr, rd} = '0;
      straps = 8'($urandom);
      addr   = '0;
      wdata  = '0;
      repeat (8) @(posedge clk);
      chk("mods in power-on reset", '0, 32'(mods));
      chk("strap valid in reset", '0, 32'(strap_ok));
      rst_b <= 1'b1;
      wait_mods();
      chk("strap value", 32'(straps), 32'(strap_val));
      chk("strap valid", 32'h1, 32'(strap_ok));
      rd_reg(STATUS_OFS, d);
      chk("status after reset", status_word(PWR_RUN, 1'b1), d);
      rd_reg(STRAP_OFS, d);
      chk("strap register", 32'(straps), d);
      rd_reg(4'h2, d);
      chk("unmapped read", '0, d);
      wr_reg(RESET_OFS, 32'h1);
      cyc(2);
      chk("digital reset", released_except(DIGITAL_MASK), 32'(mods));
      wait_mods();
      for (int i = 0; i < NUM_SINGLE; i++) begin
         wr_reg(RESET_OFS, 32'h1 << (i + 1));
         cyc(2);
         chk("single reset", released_except(SINGLE_MASK[i]), 32'(mods));
         chk("straps kept", 32'(straps), 32'(strap_val));
         wait_mods();
      end
      prev = 1'b0;
      repeat (20) begin
         @(posedge clk);
         irq_req <= 1'($urandom);
         #1 chk("irq pass through", 32'(prev), 32'(irq_pin));
         prev = irq_req;
      end
      irq_req <= 1'b0;
      wr_reg(CTRL_OFS, 32'h4);
      cyc(3);
      flips = 0;
      prev  = irq_pin;
      repeat (40) begin
         cyc(1);
         if (irq_pin !== prev) flips++;
         prev = irq_pin;
         chk("osc output inverted", 32'(!irq_pin), 32'(osc_out));
      end
      chk("irq follows oscillator", 32'h1, 32'(flips > 4));
      wr_reg(CTRL_OFS, 32'h2);
      cyc(1);
      chk("pll kept with phys up", 32'h1, 32'(pll_en));
      pd_a <= 1'b1;
      cyc(2);
      chk("pll kept with one phy up", 32'h1, 32'(pll_en));
      pd_b <= 1'b1;
      cyc(2);
      chk("pll off", '0, 32'(pll_en));
      chk("osc on with pll off", 32'h1, 32'(osc_en));
      rd_reg(STATUS_OFS, d);
      chk("status pll off", status_word(PWR_PLL_OFF, 1'b1), d);
      wr_reg(CTRL_OFS, 32'h1);
      cyc(1);
      chk("osc off", '0, 32'(osc_en));
      rd_reg(STATUS_OFS, d);
      chk("status osc off", status_word(PWR_OSC_OFF, 1'b1), d);
      halt <= 1'b1;
      cyc(10);
      chk("modules kept while halted", 32'(CHIP_MASK), 32'(mods));
      chk("osc output held low", '0, 32'(osc_out));
      halt <= 1'b0;
      wake <= 1'b1;
      cyc(1);
      wake <= 1'b0;
      n = 0;
      while (osc_en !== 1'b1 && n < 20) begin
         cyc(1);
         n++;
      end
      chk("osc resumed", 32'h1, 32'(osc_en));
      cyc(2);
      chk("pll resumed", 32'h1, 32'(pll_en));
      pd_a    <= 1'b0;
      pd_b    <= 1'b0;
      straps  <= 8'($urandom);
      pin_req <= 1'b1;
      cyc(5);
      chk("mods in pin reset", '0, 32'(mods));
      chk("straps invalid in pin reset", '0, 32'(strap_ok));
      pin_req <= 1'b0;
      wait_mods();
      chk("straps relatched", 32'(straps), 32'(strap_val));
      wrap_up();
   end
endmodule : clock_reset_distribution_tb
